// >>> pps_pkg.sv
/*
 * pps_pkg: shared constants for the per-port PHY status and control registers.
 * assumes: one switch core clock (mclk, 25 MHz) drives every user of this package.
 */
package pps_pkg;
   // register byte offsets on the internal register port
   localparam logic [7:0] PPS_OFF_P1_STAT = 8'h2E; // port 1 link status
   localparam logic [7:0] PPS_OFF_P1_CTRL = 8'h2F; // port 1 phy control and status
   localparam logic [7:0] PPS_OFF_P2_STAT = 8'h3E; // port 2 link status
   localparam logic [7:0] PPS_OFF_P2_CTRL = 8'h3F; // port 2 phy control and status
   localparam logic [7:0] PPS_OFF_P3_STAT = 8'h4E; // port 3 (mac only) status slot
   localparam logic [7:0] PPS_OFF_P3_CTRL = 8'h4F; // port 3 (mac only) control slot
   localparam logic [7:0] PPS_OFF_P4_STAT = 8'h5E; // port 4 (mac only) status slot
   localparam logic [7:0] PPS_OFF_P4_CTRL = 8'h5F; // port 4 (mac only) control slot
   // reset values
   localparam logic [7:0] PPS_STAT_RST = 8'h00; // link status register
   localparam logic [7:0] PPS_CTRL_RST = 8'h01; // control register (mode field 001)
   localparam logic [7:0] PPS_RD_NONE = 8'h00; // answer to unmapped or reserved reads
   // control register bit positions
   localparam int PPS_B_LOOP = 7; // transceiver loop
   localparam int PPS_B_RSVD = 6; // reserved, fixed zero
   localparam int PPS_B_ISOL = 5; // transceiver isolate
   localparam int PPS_B_SRST = 4; // self-clearing soft reset
   localparam int PPS_B_FLNK = 3; // force link
   // operation mode codes (bits 2..0)
   localparam logic [2:0] PPS_MODE_AN = 3'h1; // still negotiating
   localparam logic [2:0] PPS_MODE_10H = 3'h2; // 10base-t half
   localparam logic [2:0] PPS_MODE_100H = 3'h3; // 100base-tx half
   localparam logic [2:0] PPS_MODE_10F = 3'h5; // 10base-t full
   localparam logic [2:0] PPS_MODE_100F = 3'h6; // 100base-tx full
   // soft reset pulse width
   localparam int PPS_CLK_NS = 40; // mclk period
   localparam int PPS_SRST_NS = 200; // least soft reset pulse time
   localparam int PPS_SRST_CYC = (PPS_SRST_NS + PPS_CLK_NS - 1) / PPS_CLK_NS; // rounded up
   localparam logic [3:0] PPS_SRST_LOAD = 4'(PPS_SRST_CYC - 1); // counter load value
endpackage : pps_pkg

// >>> pps_port_if.sv
/*
 * pps_port_if: carrier between the register front end and one phy port slice.
 * assumes: both ends run on mclk; the front end owns the write strobe.
 */
interface pps_port_if;
   logic wr_ctrl; // one-cycle write strobe for the control register
   logic [7:0] wdata; // write data
   logic [7:0] stat_byte; // link status register contents
   logic [7:0] ctrl_byte; // control register read-back
   logic loop; // transceiver loop level
   logic isolate; // transceiver isolate level
   logic soft_rst; // soft reset level
   logic force_link; // force link level
   modport core (output wr_ctrl, wdata, input stat_byte, ctrl_byte, loop, isolate, soft_rst, force_link);
   modport port (input wr_ctrl, wdata, output stat_byte, ctrl_byte, loop, isolate, soft_rst, force_link);
endinterface : pps_port_if

// >>> pps_port.sv
/*
 * pps_port: status capture and control bits of one copper phy port.
 * assumes: phy status inputs come from logic on mclk; no synchroniser needed.
 */
module pps_port
   import pps_pkg::*;
(
   input wire logic mclk, // core clock
   input wire logic rst, // async reset, active high
   pps_port_if.port pif, // register side
   input wire logic phy_mdi, // 1 mdi, 0 mdi-x
   input wire logic phy_an_done, // negotiation finished
   input wire logic phy_link, // link good from phy
   input wire logic [4:0] phy_partner, // partner pause,100f,100h,10f,10h
   input wire logic phy_spd100, // resolved speed is 100
   input wire logic phy_full // resolved duplex is full
);
   logic [7:0] stat_q; // link status register
   logic [7:0] stat_d; // next status
   logic [2:0] mode_q; // operation mode field
   logic [2:0] mode_d; // next mode
   logic loop_q; // transceiver loop bit
   logic isol_q; // transceiver isolate bit
   logic flnk_q; // force link bit
   logic srst_q; // soft reset bit
   logic [3:0] scnt_q; // soft reset cycles left
   logic srst_set; // write asks for soft reset
   logic [2:0] res_mode; // mode from resolved speed and duplex

   // resolved mode from speed and duplex
   assign res_mode = phy_full ? (phy_spd100 ? PPS_MODE_100F : PPS_MODE_10F)
                              : (phy_spd100 ? PPS_MODE_100H : PPS_MODE_10H);
   // forced link counts as resolved; otherwise still negotiating
   assign mode_d = (phy_an_done || flnk_q) ? res_mode : PPS_MODE_AN;
   // status byte: crossover, done, link, partner abilities
   assign stat_d = {phy_mdi, phy_an_done, phy_link | flnk_q, phy_partner};
   assign srst_set = pif.wr_ctrl && pif.wdata[PPS_B_SRST];

   // status and mode follow the phy every cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stat_q <= PPS_STAT_RST;
         mode_q <= PPS_MODE_AN;
      end else begin
         stat_q <= stat_d;
         mode_q <= mode_d;
      end
   end

   // writable control bits; reserved and read-only bits are not stored
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         loop_q <= 1'b0;
         isol_q <= 1'b0;
         flnk_q <= 1'b0;
      end else if (pif.wr_ctrl) begin
         loop_q <= pif.wdata[PPS_B_LOOP];
         isol_q <= pif.wdata[PPS_B_ISOL];
         flnk_q <= pif.wdata[PPS_B_FLNK];
      end
   end

   // soft reset: set by write, clears itself after the pulse; set beats clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         srst_q <= 1'b0;
         scnt_q <= 4'h0;
      end else if (srst_set) begin
         srst_q <= 1'b1;
         scnt_q <= PPS_SRST_LOAD;
      end else if (srst_q) begin
         srst_q <= (scnt_q != 4'h0);
         scnt_q <= scnt_q - 4'h1;
      end
   end

   assign pif.stat_byte = stat_q;
   assign pif.ctrl_byte = {loop_q, 1'b0, isol_q, srst_q, flnk_q, mode_q};
   assign pif.loop = loop_q;
   assign pif.isolate = isol_q;
   assign pif.soft_rst = srst_q;
   assign pif.force_link = flnk_q;

   // soft reset holds exactly five cycles then drops
   a_srst_selfclear: assert property (@(posedge mclk) disable iff (rst)
      $rose(srst_q) ##0 !srst_set [*5]
      |-> srst_q && $past(srst_q, 1) && $past(srst_q, 2) && $past(srst_q, 3) ##1 !srst_q)
      else $error("soft reset pulse width wrong");
   // mode reflects negotiation one cycle later
   a_mode_negot: assert property (@(posedge mclk) disable iff (rst)
      !phy_an_done && !flnk_q |=> mode_q == PPS_MODE_AN)
      else $error("mode not 001 while negotiating");
   a_mode_legal: assert property (@(posedge mclk) disable iff (rst)
      mode_q != 3'h0 && mode_q != 3'h4 && mode_q != 3'h7)
      else $error("reserved mode code shown");
   a_force_link: assert property (@(posedge mclk) disable iff (rst)
      flnk_q |=> stat_q[5])
      else $error("forced link not reported good");
   c_srst: cover property (@(posedge mclk) disable iff (rst) $fell(srst_q));
endmodule : pps_port

// >>> pps_regs.sv
/*
 * pps_regs: port phy status and control register bank for the two copper ports.
 * assumes: the register port and the miim read port are driven by core logic
 * on mclk; phy status inputs are already on mclk.
 */
module pps_regs
   import pps_pkg::*;
#(
   parameter int NPORT = 2 // copper phy ports
) (
   input wire logic mclk, // core clock, 25 MHz
   input wire logic rst, // async reset, active high
   input wire logic [7:0] reg_addr, // register byte address
   input wire logic reg_wr, // write strobe, one cycle
   input wire logic reg_rd, // read strobe, one cycle
   input wire logic [7:0] reg_wdata, // write data
   output logic [7:0] reg_rdata_q, // read data
   output logic reg_rvalid_q, // read data valid pulse
   input wire logic miim_rd, // management read strobe
   input wire logic miim_port, // 0 port 1, 1 port 2
   input wire logic miim_sel, // 0 status, 1 control
   output logic [7:0] miim_rdata_q, // management read data
   output logic miim_rvalid_q, // management data valid pulse
   input wire logic [NPORT-1:0] phy_mdi, // crossover state per port
   input wire logic [NPORT-1:0] phy_an_done, // negotiation done per port
   input wire logic [NPORT-1:0] phy_link, // link good per port
   input wire logic [NPORT*5-1:0] phy_partner, // partner abilities, 5 per port
   input wire logic [NPORT-1:0] phy_spd100, // resolved 100 per port
   input wire logic [NPORT-1:0] phy_full, // resolved full duplex per port
   output logic [NPORT-1:0] transceiver_loop, // loop at phy per port
   output logic [NPORT-1:0] transceiver_isolate, // isolate phy per port
   output logic [NPORT-1:0] phy_soft_rst, // soft reset per port
   output logic [NPORT-1:0] phy_force_link, // force link per port
   output logic [NPORT-1:0] monitor_en // port acts as loop monitor
);
   logic [NPORT-1:0] hit_stat; // address hits a status register
   logic [NPORT-1:0] hit_ctrl; // address hits a control register
   logic [7:0] stat_b [NPORT]; // status bytes
   logic [7:0] ctrl_b [NPORT]; // control bytes
   logic [NPORT-1:0] loop_v; // loop bits
   logic [NPORT-1:0] mon_d; // next monitor select
   logic [NPORT-1:0] mon_q; // monitor select register
   logic [7:0] rd_mux; // selected read data
   logic [7:0] miim_mux; // selected management data
   logic [7:0] stat_off [NPORT]; // status offsets
   logic [7:0] ctrl_off [NPORT]; // control offsets

   // offsets of the two copper ports; the mac-only slots are left undecoded
   assign stat_off[0] = PPS_OFF_P1_STAT;
   assign ctrl_off[0] = PPS_OFF_P1_CTRL;
   assign stat_off[1] = PPS_OFF_P2_STAT;
   assign ctrl_off[1] = PPS_OFF_P2_CTRL;

   // one slice per copper port
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      pps_port_if pif ();
      // address decode per port; the status offset only ever answers reads
      assign hit_stat[p] = (reg_addr == stat_off[p]);
      assign hit_ctrl[p] = (reg_addr == ctrl_off[p]);
      assign pif.wr_ctrl = reg_wr && hit_ctrl[p]; // status offsets take no writes
      assign pif.wdata = reg_wdata;
      assign stat_b[p] = pif.stat_byte;
      assign ctrl_b[p] = pif.ctrl_byte;
      assign loop_v[p] = pif.loop;
      assign transceiver_loop[p] = pif.loop;
      assign transceiver_isolate[p] = pif.isolate;
      assign phy_soft_rst[p] = pif.soft_rst;
      assign phy_force_link[p] = pif.force_link;
      // the other copper port monitors a looped port
      assign mon_d[p] = loop_v[NPORT-1-p];
      pps_port u_port (
         .mclk (mclk),
         .rst (rst),
         .pif (pif),
         .phy_mdi (phy_mdi[p]),
         .phy_an_done (phy_an_done[p]),
         .phy_link (phy_link[p]),
         .phy_partner (phy_partner[p*5 +: 5]),
         .phy_spd100 (phy_spd100[p]),
         .phy_full (phy_full[p])
      );
   end

   // read decode; mac-only port slots and unmapped offsets read zero
   // the copper ports never share an offset, so the order of the chain does not matter
   assign rd_mux = hit_stat[0] ? stat_b[0] :
                   hit_ctrl[0] ? ctrl_b[0] :
                   hit_stat[1] ? stat_b[1] :
                   hit_ctrl[1] ? ctrl_b[1] : PPS_RD_NONE;
   // management view of the same bytes
   assign miim_mux = miim_sel ? ctrl_b[miim_port] : stat_b[miim_port];

   // monitor select register
   // a looped port hands its traffic to the other copper port, one cycle behind the loop bit
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mon_q <= '0;
      end else begin
         mon_q <= mon_d;
      end
   end
   assign monitor_en = mon_q;

   // register port read answer, one cycle after the strobe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata_q <= PPS_RD_NONE;
         reg_rvalid_q <= 1'b0;
      end else begin
         reg_rvalid_q <= reg_rd;
         if (reg_rd) begin
            reg_rdata_q <= rd_mux;
         end
      end
   end

   // management read answer, one cycle after the strobe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         miim_rdata_q <= PPS_RD_NONE;
         miim_rvalid_q <= 1'b0;
      end else begin
         miim_rvalid_q <= miim_rd;
         if (miim_rd) begin
            miim_rdata_q <= miim_mux;
         end
      end
   end

   // read answer comes exactly one cycle after the strobe
   a_rd_answer: assert property (@(posedge mclk) disable iff (rst)
      reg_rd |=> reg_rvalid_q ##1 (reg_rvalid_q == $past(reg_rd)))
      else $error("read answer timing wrong");
   // mac-only port slots read zero
   a_rsvd_ports: assert property (@(posedge mclk) disable iff (rst)
      reg_rd && (reg_addr == PPS_OFF_P3_CTRL || reg_addr == PPS_OFF_P4_CTRL
                 || reg_addr == PPS_OFF_P3_STAT || reg_addr == PPS_OFF_P4_STAT)
      |=> reg_rdata_q == PPS_RD_NONE)
      else $error("mac-only port slot read not zero");
   // status read returns the phy state captured one cycle earlier
   a_stat_read: assert property (@(posedge mclk) disable iff (rst)
      reg_rd && reg_addr == PPS_OFF_P1_STAT && $stable(phy_partner[4:0]) && $stable(phy_mdi[0])
      |=> reg_rdata_q[4:0] == $past(phy_partner[4:0], 2) && reg_rdata_q[7] == $past(phy_mdi[0], 2))
      else $error("status read mismatch");
   // writing a status offset leaves the loop, isolate and force link bits untouched
   a_ro_write: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && !(|hit_ctrl) |=> $stable(transceiver_loop) && $stable(transceiver_isolate)
      && $stable(phy_force_link))
      else $error("write to read-only offset changed control");
   // reserved bit 6 always reads zero
   a_rsvd_bit: assert property (@(posedge mclk) disable iff (rst)
      reg_rd && (|hit_ctrl) |=> !reg_rdata_q[PPS_B_RSVD])
      else $error("reserved bit 6 read as one");
   // loop bit written to port 2 makes port 1 monitor two cycles later
   a_loop_mon: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == PPS_OFF_P2_CTRL && reg_wdata[PPS_B_LOOP] ##1 !reg_wr
      |=> transceiver_loop[1] && monitor_en[0])
      else $error("port 2 loop without port 1 monitor");
   a_mon_cross: assert property (@(posedge mclk) disable iff (rst)
      ##1 monitor_en[1] == $past(transceiver_loop[0]))
      else $error("port 2 monitor does not follow port 1 loop");
   a_isolate: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == PPS_OFF_P1_CTRL |=> transceiver_isolate[0] == $past(reg_wdata[PPS_B_ISOL]))
      else $error("isolate bit not taken");
   a_miim_view: assert property (@(posedge mclk) disable iff (rst)
      miim_rd && !miim_sel && !miim_port |=> miim_rvalid_q && miim_rdata_q == $past(stat_b[0]))
      else $error("management status view mismatch");
   // port 2 status read carries the partner abilities
   a_partner_p2: assert property (@(posedge mclk) disable iff (rst)
      reg_rd && reg_addr == PPS_OFF_P2_STAT && $stable(phy_partner[9:5])
      |=> reg_rdata_q[4:0] == $past(phy_partner[9:5], 2))
      else $error("port 2 partner abilities mismatch");
   // negotiation done and link good reach the port 2 status byte
   a_link_p2: assert property (@(posedge mclk) disable iff (rst)
      reg_rd && reg_addr == PPS_OFF_P2_STAT && $stable(phy_an_done[1]) && $stable(phy_link[1])
      && !phy_force_link[1] && $stable(phy_force_link[1])
      |=> reg_rdata_q[6:5] == {$past(phy_an_done[1], 2), $past(phy_link[1], 2)})
      else $error("port 2 done or link bit mismatch");
   // port 1 loop level follows the written bit
   a_loop_take: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == PPS_OFF_P1_CTRL |=> transceiver_loop[0] == $past(reg_wdata[PPS_B_LOOP]))
      else $error("port 1 loop bit not taken");
   // port 1 force link level follows the written bit
   a_flink_take: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == PPS_OFF_P1_CTRL |=> phy_force_link[0] == $past(reg_wdata[PPS_B_FLNK]))
      else $error("port 1 force link bit not taken");
   // port 2 isolate level follows the written bit
   a_iso_p2: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == PPS_OFF_P2_CTRL |=> transceiver_isolate[1] == $past(reg_wdata[PPS_B_ISOL]))
      else $error("port 2 isolate bit not taken");
   // port 2 force link level follows the written bit
   a_flink_p2: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == PPS_OFF_P2_CTRL |=> phy_force_link[1] == $past(reg_wdata[PPS_B_FLNK]))
      else $error("port 2 force link bit not taken");
   // a soft reset write starts the pulse on the next cycle
   a_srst_take: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == PPS_OFF_P2_CTRL && reg_wdata[PPS_B_SRST] |=> phy_soft_rst[1])
      else $error("port 2 soft reset not started");
   // control bit 4 reads back the live soft reset level
   a_srst_ctrl: assert property (@(posedge mclk) disable iff (rst)
      reg_rd && reg_addr == PPS_OFF_P1_CTRL |=> reg_rdata_q[PPS_B_SRST] == $past(phy_soft_rst[0]))
      else $error("soft reset bit read back wrong");
   // port 1 monitors the port 2 loop
   a_mon_p1: assert property (@(posedge mclk) disable iff (rst)
      ##1 monitor_en[0] == $past(transceiver_loop[1]))
      else $error("port 1 monitor does not follow port 2 loop");
   // management control view of port 2
   a_miim_ctrl: assert property (@(posedge mclk) disable iff (rst)
      miim_rd && miim_sel && miim_port |=> miim_rvalid_q && miim_rdata_q == $past(ctrl_b[1]))
      else $error("management control view mismatch");
   c_loop1: cover property (@(posedge mclk) disable iff (rst) transceiver_loop[0] && monitor_en[1]);
   c_srst2: cover property (@(posedge mclk) disable iff (rst) $rose(phy_soft_rst[1]));
   c_miim: cover property (@(posedge mclk) disable iff (rst) miim_rvalid_q && miim_sel);
   c_flink: cover property (@(posedge mclk) disable iff (rst) phy_force_link[0] && !phy_link[0]);
endmodule : pps_regs

// >>> pps_link_peer.sv
/*
 * pps_link_peer: behavioural remote link partner seen through both copper phys.
 * assumes: the bench sets a profile per port; outputs move on mclk only.
 */
module pps_link_peer
   import pps_pkg::*;
(
   input wire logic mclk, // core clock
   input wire logic rst, // async reset, active high
   input wire logic [1:0] soft_rst, // phy soft reset per port
   input wire logic [1:0] isolate, // transceiver_isolate per port
   input wire logic [19:0] prof, // per port {mdi,an,link,spd,full,partner[4:0]}
   output logic [1:0] phy_mdi, // crossover state
   output logic [1:0] phy_an_done, // negotiation done
   output logic [1:0] phy_link, // link good
   output logic [9:0] phy_partner, // partner abilities
   output logic [1:0] phy_spd100, // resolved 100
   output logic [1:0] phy_full // resolved full duplex
);
   // a reset phy renegotiates, an isolated phy loses the link
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         {phy_mdi, phy_an_done, phy_link, phy_spd100, phy_full} <= 10'h000;
         phy_partner <= 10'h000;
      end else begin
         for (int p = 0; p < 2; p++) begin
            phy_mdi[p] <= prof[p*10+9];
            phy_an_done[p] <= prof[p*10+8] & ~soft_rst[p];
            phy_link[p] <= prof[p*10+7] & ~soft_rst[p] & ~isolate[p];
            phy_spd100[p] <= prof[p*10+6];
            phy_full[p] <= prof[p*10+5];
            phy_partner[p*5+:5] <= prof[p*10+:5];
         end
      end
   end
endmodule // pps_link_peer

// >>> pps_regs_tb.sv
/*
 * pps_regs_tb: self-checking bench for the port phy status and control bank.
 * assumes: pps_regs with two copper ports and pps_link_peer on its phy side.
 */
module pps_regs_tb
   import pps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, rst, reg_wr, reg_rd, miim_rd, miim_port, miim_sel; // bench drives
   logic [7:0] reg_addr, reg_wdata, d; // address, write data, read result
   logic [7:0] rdata, mdata; // read data from both ports
   logic rvalid, mvalid; // read valid pulses
   logic [19:0] prof; // link partner profile
   logic [1:0] mdi, an, lnk, spd, full, loop, iso, srst, fl, mon; // phy side
   logic [9:0] partner; // partner abilities
   logic [1:0] e_loop, e_iso, e_fl; // expected control levels
   int num_errors, comparisons, n; // counters
   logic [7:0] ro_offs [5] = '{PPS_OFF_P1_STAT, PPS_OFF_P2_STAT, PPS_OFF_P3_CTRL, PPS_OFF_P4_CTRL, 8'h77}; // no writes
   logic [7:0] rsv_offs [5] = '{PPS_OFF_P3_STAT, PPS_OFF_P3_CTRL, PPS_OFF_P4_STAT, PPS_OFF_P4_CTRL, 8'h77}; // read zero
   pps_regs dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid), .miim_rd(miim_rd),
      .miim_port(miim_port), .miim_sel(miim_sel), .miim_rdata_q(mdata), .miim_rvalid_q(mvalid),
      .phy_mdi(mdi), .phy_an_done(an), .phy_link(lnk), .phy_partner(partner), .phy_spd100(spd),
      .phy_full(full), .transceiver_loop(loop), .transceiver_isolate(iso), .phy_soft_rst(srst),
      .phy_force_link(fl), .monitor_en(mon));
   pps_link_peer peer (.mclk(mclk), .rst(rst), .soft_rst(srst), .isolate(iso), .prof(prof),
      .phy_mdi(mdi), .phy_an_done(an), .phy_link(lnk), .phy_partner(partner), .phy_spd100(spd),
      .phy_full(full));
   // 25 MHz core clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // expected status byte of a copper port
   function automatic logic [7:0] exp_stat(int p);
      logic [9:0] pr;
      pr = prof[p*10+:10];
      return {pr[9], pr[8], (pr[7] & ~e_iso[p]) | e_fl[p], pr[4:0]};
   endfunction
   // expected control byte, mode from the resolved speed and duplex
   function automatic logic [7:0] exp_ctrl(int p);
      logic [9:0] pr;
      logic [2:0] m;
      pr = prof[p*10+:10];
      case (pr[6:5])
         2'h0: m = PPS_MODE_10H;
         2'h2: m = PPS_MODE_100H;
         2'h1: m = PPS_MODE_10F;
         default: m = PPS_MODE_100F;
      endcase
      if (!pr[8] && !e_fl[p]) m = PPS_MODE_AN; // still negotiating
      return {e_loop[p], 1'b0, e_iso[p], 1'b0, e_fl[p], m};
   endfunction
   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] v);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      chk("reg valid", {7'h00, rvalid}, 8'h01);
      d = rdata;
   endtask
   task automatic mrd(logic p, logic s);
      @(negedge mclk);
      miim_port = p;
      miim_sel = s;
      miim_rd = 1'b1;
      @(negedge mclk);
      miim_rd = 1'b0;
      chk("miim valid", {7'h00, mvalid}, 8'h01);
      d = mdata;
   endtask
   // all four views of one copper port
   task automatic check_port(int p);
      rd(p ? PPS_OFF_P2_STAT : PPS_OFF_P1_STAT);
      chk("status", d, exp_stat(p));
      rd(p ? PPS_OFF_P2_CTRL : PPS_OFF_P1_CTRL);
      chk("control", d, exp_ctrl(p));
      mrd(p[0], 1'b0);
      chk("miim status", d, exp_stat(p));
      mrd(p[0], 1'b1);
      chk("miim control", d, exp_ctrl(p));
   endtask
   task automatic check_outs();
      chk("loop", {6'h00, loop}, {6'h00, e_loop});
      chk("monitor", {6'h00, mon}, {6'h00, e_loop[0], e_loop[1]});
      chk("isolate", {6'h00, iso}, {6'h00, e_iso});
      chk("force link", {6'h00, fl}, {6'h00, e_fl});
      chk("soft reset", {6'h00, srst}, 8'h00);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      #1000000;
      num_errors++;
      $display("watchdog expired");
      complete_run();
   end
   // main sequence
   initial begin
      {rst, reg_wr, reg_rd, miim_rd, miim_port, miim_sel} = 6'h20;
      {reg_addr, reg_wdata, prof} = 36'h0;
      {e_loop, e_iso, e_fl} = 6'h00;
      {num_errors, comparisons} = 0;
      void'($urandom(32'hDB9DFC3E));
      repeat (12) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      check_port(0);
      check_port(1);
      check_outs();
      $display("test reset values done");
      // every mode code, negotiation pending first
      for (int i = 0; i < 5; i++) begin
         prof = 20'($urandom);
         for (int p = 0; p < 2; p++)
            prof[p*10+5+:4] = (i == 0) ? 4'h0 : {2'h2, 2'(i - 1)};
         repeat (3) @(negedge mclk);
         check_port(0);
         check_port(1);
      end
      $display("test mode codes done");
      // random profiles with random control writes, soft reset kept off
      repeat (12) begin
         prof = 20'($urandom);
         for (int p = 0; p < 2; p++) begin
            n = $urandom;
            wr(p ? PPS_OFF_P2_CTRL : PPS_OFF_P1_CTRL, 8'(n) & 8'hEF);
            {e_loop[p], e_iso[p], e_fl[p]} = {n[7], n[5], n[3]};
         end
         repeat (3) @(negedge mclk);
         check_outs();
         check_port(0);
         check_port(1);
      end
      $display("test random traffic done");
      // writes to read-only, mac-only and unmapped places
      foreach (ro_offs[i])
         wr(ro_offs[i], 8'hFF);
      foreach (rsv_offs[i]) begin
         rd(rsv_offs[i]);
         chk("reserved read", d, PPS_RD_NONE);
      end
      check_port(0);
      check_port(1);
      check_outs();
      $display("test refused access done");
      // soft reset pulse width and self clear
      wr(PPS_OFF_P1_CTRL, 8'h10);
      e_loop[0] = 1'b0;
      e_iso[0] = 1'b0;
      e_fl[0] = 1'b0;
      n = 0;
      while (srst[0] === 1'b1 && n < 20) begin
         n++;
         @(negedge mclk);
      end
      chk("soft reset cycles", 8'(n), 8'(PPS_SRST_CYC));
      // port 2: the control byte must show bit 4 while the pulse runs
      wr(PPS_OFF_P2_CTRL, 8'h10);
      {e_loop[1], e_iso[1], e_fl[1]} = 3'h0;
      rd(PPS_OFF_P2_CTRL);
      chk("soft reset bit", {7'h00, d[PPS_B_SRST]}, 8'h01);
      repeat (3) @(negedge mclk);
      check_port(0);
      check_port(1);
      check_outs();
      $display("test soft reset done");
      complete_run();
   end
endmodule // pps_regs_tb
